// *** hdl/mrf_mode_register.sv ***
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1 - Set command with select 100 loads register
// R2 - Controller holds row, column, write-enable low
// R3 - Controller writes zero to reserved bits
// R4 - Bit 13 enables permanent repair mode
// R5 - Bit 12 selects two-clock write preamble
// R6 - Bit 11 selects two-clock read preamble
// R7 - Two-clock write preamble needs higher latency
// R8 - Some even latencies add two clocks
// R9 - Bit 10 enables read preamble training
// R10 - Bit 9 enables self-refresh abort
// R11 - Bits 8:6 encode command-address latency
// R12 - No 3/5 clock latency in quarter-rate
// R13 - Bit 5 enables temporary repair mode
// R14 - Bit 4 vref monitor, bit 1 power save
// R15 - Bit 3 enables temperature-controlled refresh
// R16 - Bit 2 selects extended temperature range
// R17 - Readout page 2 bit 7: permanent available
// R18 - Permanent repair one row, irreversible
// R19 - Readout page 2 bit 6: temporary available
// R20 - Temporary repair undone by reset/powerdown/rewrite
// R21 - Quarter-rate entered by set command plus sync
// R22 - Half rate needs no command or sync
// R23 - Per-device mode masks commands for others
// R24 - Control register bit 4 enables per-device
// R25 - Control register bit 3 selects gear-down
module mrf_mode_register #(
	parameter int               BANKS       = 16,
	parameter logic             PERM_AVAIL  = 1'b1,
	parameter logic             TEMP_AVAIL  = 1'b1
) (
	input  wire logic                  clk_sys_in,
	input  wire logic                  resetn_in,
	input  wire logic                  ck_in,
	input  wire logic                  cs_n_in,
	input  wire logic                  act_n_in,
	input  wire logic                  ras_n_in,
	input  wire logic                  cas_n_in,
	input  wire logic                  we_n_in,
	input  wire logic [1:0]            bank_group_in,
	input  wire logic [1:0]            bank_in,
	input  wire logic [17:0]           addr_in,
	input  wire logic                  dq0_select_in,
	input  wire logic                  sync_pulse_in,
	input  wire logic                  power_down_in,
	input  wire logic                  repair_write_in,
	input  wire logic [3:0]            repair_bank_in,
	input  wire logic                  readout_en_in,
	input  wire logic [1:0]            readout_page_in,
	output logic [21:0]                mode_value_out,
	output mrf_pkg::mrf_cfg_s          cfg_out,
	output logic                       quarter_rate_mode_out,
	output logic                       per_device_mode_out,
	output logic [7:0]                 readout_data_out,
	output logic [15:0]                perm_repaired_out,
	output logic [15:0]                temp_repaired_out,
	output logic                       set_seen_out
);

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	// Every pin except readout enable and page passes two flops; stage one is read only by stage two
	localparam int NSYNC = 36;
	logic [NSYNC-1:0] pins_raw;
	logic [NSYNC-1:0] sync1_reg;
	logic [NSYNC-1:0] sync2_reg;
	logic             ck_prev_reg;

	assign pins_raw = {ck_in, cs_n_in, act_n_in, ras_n_in, cas_n_in,
		we_n_in, bank_group_in, bank_in, addr_in, dq0_select_in,
		sync_pulse_in, power_down_in, repair_write_in, repair_bank_in};

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			sync1_reg   <= '1;
			sync2_reg   <= '1;
			ck_prev_reg <= 1'b1;
		end
		else
		begin
			sync1_reg   <= pins_raw;
			sync2_reg   <= sync1_reg;
			ck_prev_reg <= sync2_reg[NSYNC-1];
		end
	end

	// Named views of the synchronised pins
	logic        s_ck;
	logic        s_cs_n;
	logic        s_act_n;
	logic        s_ras_n;
	logic        s_cas_n;
	logic        s_we_n;
	logic [1:0]  s_bg;
	logic [1:0]  s_ba;
	logic [17:0] s_addr;
	logic        s_dq0;
	logic        s_sync;
	logic        s_pd;
	logic        s_rep_wr;
	logic [3:0]  s_rep_bank;
	logic        ck_rise;

	assign {s_ck, s_cs_n, s_act_n, s_ras_n, s_cas_n, s_we_n, s_bg, s_ba,
		s_addr, s_dq0, s_sync, s_pd, s_rep_wr, s_rep_bank} = sync2_reg;
	assign ck_rise = s_ck && !ck_prev_reg;

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	logic       gear_quarter_reg;
	logic       per_device_reg;
	logic       phase_reg;
	logic       sample_edge;
	logic       is_set_cmd;
	logic       addressed;
	logic [2:0] sel_code;
	logic [21:0] cmd_word;

	// In quarter rate only the aligned phase samples control lines
	assign sample_edge = ck_rise && (!gear_quarter_reg || phase_reg); // R21
	assign is_set_cmd  = sample_edge && !s_cs_n && s_act_n &&
		!s_ras_n && !s_cas_n && !s_we_n;                       // R2
	// Low data bit selects this device when per-device mode is on
	assign addressed   = !per_device_reg || !s_dq0;               // R23
	assign cmd_word    = {s_bg, s_ba, s_addr};
	assign sel_code    = cmd_word[mrf_pkg::SEL_HI:mrf_pkg::SEL_LO];

	// ------------------------------------------------------------
	// Mode register storage
	// ------------------------------------------------------------
	logic [21:0] mode_reg;
	logic        set_seen_reg;

	// Reserved bits are stored as written; controller keeps them zero
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			mode_reg <= mrf_pkg::MR_RESET;
		else if (is_set_cmd && addressed &&
			sel_code == mrf_pkg::SEL_PREAMBLE)                 // R1 R3
			mode_reg <= cmd_word;
	end

	// Pulse per accepted load, for observers
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			set_seen_reg <= 1'b0;
		else
			set_seen_reg <= is_set_cmd && addressed &&
				sel_code == mrf_pkg::SEL_PREAMBLE;
	end

	// Control register bits that this block depends on
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			per_device_reg <= 1'b0;
		else if (is_set_cmd && addressed &&
			sel_code == mrf_pkg::SEL_MPR_CTRL)
			per_device_reg <= cmd_word[mrf_pkg::BIT_PER_DEVICE]; // R24
	end

	// ------------------------------------------------------------
	// Gear-down alignment
	// ------------------------------------------------------------
	// Half rate needs nothing; quarter rate waits for the sync pulse
	mrf_pkg::mrf_gear_e gear_reg;
	logic               sync_prev_reg;
	logic               sync_rise;

	assign sync_rise = s_sync && !sync_prev_reg;

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			sync_prev_reg <= 1'b1;   // As synchroniser reset, no false edge
		else
			sync_prev_reg <= s_sync;
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			gear_reg <= mrf_pkg::GEAR_HALF;                    // R21 R22
		else
		begin
			case (gear_reg)
				mrf_pkg::GEAR_HALF:
					if (is_set_cmd && addressed &&
						sel_code == mrf_pkg::SEL_MPR_CTRL &&
						cmd_word[mrf_pkg::BIT_GEAR_DOWN])          // R25
						gear_reg <= mrf_pkg::GEAR_ARMED;
				mrf_pkg::GEAR_ARMED:
					if (sync_rise)
						gear_reg <= mrf_pkg::GEAR_QUART;           // R21
				mrf_pkg::GEAR_QUART:
					if (is_set_cmd && addressed &&
						sel_code == mrf_pkg::SEL_MPR_CTRL &&
						!cmd_word[mrf_pkg::BIT_GEAR_DOWN])         // R25
						gear_reg <= mrf_pkg::GEAR_HALF;
				default:
					gear_reg <= mrf_pkg::GEAR_HALF;
			endcase
		end
	end

	assign gear_quarter_reg = (gear_reg == mrf_pkg::GEAR_QUART);

	// Phase toggles per rising pin-clock edge; sync pulse fixes the sample phase
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			phase_reg <= 1'b1;
		else if (gear_reg == mrf_pkg::GEAR_ARMED && sync_rise)
			phase_reg <= 1'b0;                                 // R21
		else if (ck_rise)
			phase_reg <= !phase_reg;
	end

	// ------------------------------------------------------------
	// Repair bookkeeping
	// ------------------------------------------------------------
	logic [15:0] perm_reg;
	logic [15:0] temp_reg;
	logic        rep_wr_prev_reg;
	logic        rep_wr_rise;

	assign rep_wr_rise = s_rep_wr && !rep_wr_prev_reg;

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			rep_wr_prev_reg <= 1'b1; // As synchroniser reset, no false edge
		else
			rep_wr_prev_reg <= s_rep_wr;
	end

	// Permanent: one row per bank, never cleared except by resetn_in
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			perm_reg <= 16'h0000;
		else if (rep_wr_rise && PERM_AVAIL &&
			mode_reg[mrf_pkg::BIT_PERM_REPAIR] &&
			!perm_reg[s_rep_bank])                             // R4 R18
			perm_reg[s_rep_bank] <= 1'b1;
	end

	// Temporary: a new write in the bank replaces, power-down clears
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			temp_reg <= 16'h0000;                              // R20
		else if (s_pd)
			temp_reg <= 16'h0000;                              // R20
		else if (rep_wr_rise && TEMP_AVAIL &&
			mode_reg[mrf_pkg::BIT_TEMP_REPAIR])                // R13 R20
			temp_reg[s_rep_bank] <= 1'b1;
	end

	// ------------------------------------------------------------
	// Field decode and readout
	// ------------------------------------------------------------
	mrf_pkg::mrf_cfg_s cfg;
	logic [3:0]        cal_clk;

	// Latency code table; reserved codes fall back to disabled
	always_comb
	begin
		case (mode_reg[mrf_pkg::CAL_HI:mrf_pkg::CAL_LO])           // R11
			3'h0:    cal_clk = mrf_pkg::CAL_CLK_0;
			3'h1:    cal_clk = mrf_pkg::CAL_CLK_3;
			3'h2:    cal_clk = mrf_pkg::CAL_CLK_4;
			3'h3:    cal_clk = mrf_pkg::CAL_CLK_5;
			3'h4:    cal_clk = mrf_pkg::CAL_CLK_6;
			3'h5:    cal_clk = mrf_pkg::CAL_CLK_8;
			default: cal_clk = mrf_pkg::CAL_CLK_0;
		endcase
	end

	always_comb
	begin
		cfg.perm_repair_en     = mode_reg[mrf_pkg::BIT_PERM_REPAIR];   // R4
		cfg.temp_repair_en     = mode_reg[mrf_pkg::BIT_TEMP_REPAIR];   // R13
		cfg.write_preamble_two = mode_reg[mrf_pkg::BIT_WR_PREAMBLE];   // R5
		cfg.read_preamble_two  = mode_reg[mrf_pkg::BIT_RD_PREAMBLE];   // R6
		cfg.read_training_en   = mode_reg[mrf_pkg::BIT_RD_TRAINING];   // R9
		cfg.sr_abort_en        = mode_reg[mrf_pkg::BIT_SR_ABORT];      // R10
		cfg.cal_clocks         = cal_clk;                              // R11
		cfg.cal_reserved       = mode_reg[mrf_pkg::CAL_HI] &&
			mode_reg[mrf_pkg::CAL_HI-1];                                // R11
		cfg.vref_monitor_en    = mode_reg[mrf_pkg::BIT_VREF_MON];      // R14
		cfg.tcr_en             = mode_reg[mrf_pkg::BIT_TCR_EN];        // R15
		cfg.tcr_extended       = mode_reg[mrf_pkg::BIT_TCR_RANGE];     // R16
		cfg.max_power_save     = mode_reg[mrf_pkg::BIT_MAX_PWR_SAVE];  // R14
	end

	// Readout of page 2 location 0; other pages read zero
	logic [7:0] readout_reg;

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			readout_reg <= 8'h00;
		else if (readout_en_in && readout_page_in == mrf_pkg::READOUT_PAGE)
		begin
			readout_reg <= 8'h00;
			readout_reg[mrf_pkg::READOUT_PERM_BIT] <= PERM_AVAIL;     // R17
			readout_reg[mrf_pkg::READOUT_TEMP_BIT] <= TEMP_AVAIL;     // R19
		end
		else
			readout_reg <= 8'h00;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign mode_value_out        = mode_reg;
	assign cfg_out               = cfg;
	assign quarter_rate_mode_out = gear_quarter_reg;
	assign per_device_mode_out   = per_device_reg;
	assign readout_data_out      = readout_reg;
	assign perm_repaired_out     = perm_reg;
	assign temp_repaired_out     = temp_reg;
	assign set_seen_out          = set_seen_reg;

endmodule // mrf_mode_register

`default_nettype wire

// *** hdl/mrf_pkg.sv ***
`default_nettype none

package mrf_pkg;

	// ------------------------------------------------------------
	// Mode register field positions
	// ------------------------------------------------------------
	localparam int MR_WIDTH          = 22;
	localparam int SEL_HI            = 20;
	localparam int SEL_LO            = 18;
	localparam int BIT_RSV_HI        = 21;
	localparam int BIT_RSV_MID       = 17;
	localparam int BIT_RSV_LO        = 0;
	localparam int BIT_PERM_REPAIR   = 13;
	localparam int BIT_WR_PREAMBLE   = 12;
	localparam int BIT_RD_PREAMBLE   = 11;
	localparam int BIT_RD_TRAINING   = 10;
	localparam int BIT_SR_ABORT      = 9;
	localparam int CAL_HI            = 8;
	localparam int CAL_LO            = 6;
	localparam int BIT_TEMP_REPAIR   = 5;
	localparam int BIT_VREF_MON      = 4;
	localparam int BIT_TCR_EN        = 3;
	localparam int BIT_TCR_RANGE     = 2;
	localparam int BIT_MAX_PWR_SAVE  = 1;

	// Fields of the multipurpose-control register (select 011)
	localparam int BIT_PER_DEVICE    = 4;
	localparam int BIT_GEAR_DOWN     = 3;

	// Register select codes
	localparam logic [2:0] SEL_MPR_CTRL   = 3'h3;
	localparam logic [2:0] SEL_PREAMBLE   = 3'h4;

	// Readout page/location/bit positions
	localparam logic [1:0] READOUT_PAGE   = 2'h2;
	localparam int READOUT_PERM_BIT       = 7;
	localparam int READOUT_TEMP_BIT       = 6;

	// Reset values
	localparam logic [21:0] MR_RESET      = 22'h000000;

	// Command-address latency in clocks per code
	localparam logic [3:0] CAL_CLK_0      = 4'h0;
	localparam logic [3:0] CAL_CLK_3      = 4'h3;
	localparam logic [3:0] CAL_CLK_4      = 4'h4;
	localparam logic [3:0] CAL_CLK_5      = 4'h5;
	localparam logic [3:0] CAL_CLK_6      = 4'h6;
	localparam logic [3:0] CAL_CLK_8      = 4'h8;

	// Decoded settings handed to the core
	typedef struct packed {
		logic       perm_repair_en;
		logic       temp_repair_en;
		logic       write_preamble_two;
		logic       read_preamble_two;
		logic       read_training_en;
		logic       sr_abort_en;
		logic [3:0] cal_clocks;
		logic       cal_reserved;
		logic       vref_monitor_en;
		logic       tcr_en;
		logic       tcr_extended;
		logic       max_power_save;
	} mrf_cfg_s;

	// Gear-down alignment sequence
	typedef enum logic [2:0] {
		GEAR_HALF   = 3'b001,
		GEAR_ARMED  = 3'b010,
		GEAR_QUART  = 3'b100
	} mrf_gear_e;

endpackage : mrf_pkg

`default_nettype wire

// *** tb/mrf_props.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Mode register checker
// ----------------------------------------
module mrf_props #(
	parameter logic PERM_AVAIL = 1'b1,
	parameter logic TEMP_AVAIL = 1'b1
) (
	input  wire logic              clk_sys_in,
	input  wire logic              resetn_in,
	input  wire logic              power_down_in,
	input  wire logic              readout_en_in,
	input  wire logic [1:0]        readout_page_in,
	input  wire logic [21:0]       mode_value_out,
	input  wire mrf_pkg::mrf_cfg_s cfg_out,
	input  wire logic [7:0]        readout_data_out,
	input  wire logic [15:0]       perm_repaired_out,
	input  wire logic [15:0]       temp_repaired_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);

	AST_LOAD_SEL: assert property (
		$changed(mode_value_out) |-> mode_value_out[20:18] == 3'h4)
		else $error("Register changed on a foreign select");
	AST_PERM_EN: assert property (
		cfg_out.perm_repair_en == mode_value_out[13])
		else $error("Permanent repair enable wrong");
	AST_PREAMBLE: assert property (
		{cfg_out.write_preamble_two, cfg_out.read_preamble_two}
		== mode_value_out[12:11]) else $error("Preamble wrong");
	AST_TRAIN_ABORT: assert property (
		{cfg_out.read_training_en, cfg_out.sr_abort_en}
		== mode_value_out[10:9]) else $error("Training or abort wrong");
	AST_CAL: assert property (
		cfg_out.cal_clocks == 4'(32'h00865430 >> {mode_value_out[8:6], 2'b00})
		&& cfg_out.cal_reserved == (mode_value_out[8:7] == 2'b11))
		else $error("Latency decode wrong");
	AST_TEMP_EN: assert property (
		cfg_out.temp_repair_en == mode_value_out[5])
		else $error("Temporary repair enable wrong");
	AST_VREF_PWR: assert property (
		{cfg_out.vref_monitor_en, cfg_out.max_power_save}
		== {mode_value_out[4], mode_value_out[1]}) else $error("Monitor wrong");
	AST_TCR: assert property (
		{cfg_out.tcr_en, cfg_out.tcr_extended} == mode_value_out[3:2])
		else $error("Refresh control wrong");
	AST_READOUT: assert property (
		readout_en_in && readout_page_in == 2'h2 |=>
		readout_data_out == {PERM_AVAIL, TEMP_AVAIL, 6'h00})
		else $error("Readout wrong");
	AST_PERM_KEEP: assert property (
		($past(perm_repaired_out) & ~perm_repaired_out) == 16'h0000)
		else $error("Permanent repair undone");
	AST_TEMP_CLR: assert property (
		power_down_in [*4] |-> temp_repaired_out == 16'h0000)
		else $error("Temporary repair kept in power-down");

	// Main scenarios reached
	cover property (mode_value_out[13]);
	cover property (|perm_repaired_out);
	cover property (readout_en_in);
endmodule // mrf_props

bind mrf_mode_register mrf_props #(
	.PERM_AVAIL(PERM_AVAIL),
	.TEMP_AVAIL(TEMP_AVAIL)
) i_props (
	.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
	.power_down_in(power_down_in), .readout_en_in(readout_en_in),
	.readout_page_in(readout_page_in), .mode_value_out(mode_value_out),
	.cfg_out(cfg_out), .readout_data_out(readout_data_out),
	.perm_repaired_out(perm_repaired_out),
	.temp_repaired_out(temp_repaired_out)
);

`default_nettype wire

// *** tb/mrf_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Controller driving the command pins
// ----------------------------------------
module mrf_ctrl_model (
	input  wire logic   clk_sys_in,
	output logic        ck_out,
	output logic [4:0]  cmd_n_out,
	output logic [21:0] word_out,
	output logic        sync_out
);
	logic armed;
	logic qr;
	int   write_latency;

	// Lowest write latency of the clock range; arbitrary plain default
	localparam int WL_BASE = 9;

	// Idle: pin clock parked low, no command
	initial
	begin
		ck_out = 1'b0;
		cmd_n_out = 5'h1f;
		word_out = 22'h0;
		sync_out = 1'b0;
		armed = 1'b0;
		qr = 1'b0;
		write_latency = WL_BASE;
	end

	// One period of the pin clock
	task automatic tick;
		repeat (8) @(posedge clk_sys_in);
		#1 ck_out = 1'b1;
		repeat (8) @(posedge clk_sys_in);
		#1 ck_out = 1'b0;
	endtask

	// Held two periods in quarter rate so one aligned edge sees it
	task automatic send(input logic [21:0] w);
		logic [21:0] v;
		v = w & ~22'h220001;
		if (qr && v[20:18] == 3'h4 && !v[8] && v[6])
			v[6] = 1'b0;
		// Two-clock write preamble costs latency on this side
		if (v[20:18] == 3'h4)
		begin
			write_latency = WL_BASE + int'(v[12]);
			if (v[12] && write_latency % 2 == 0)
				write_latency = write_latency + 2;
		end
		@(posedge clk_sys_in);
		#1 word_out = v;
		cmd_n_out = 5'b01000;
		repeat (qr ? 2 : 1) tick;
		cmd_n_out = 5'h1f;
		word_out = ~v; // Released bus must not show stale value
		if (v[20:18] == 3'h3)
		begin
			armed = v[3];
			qr = qr & v[3];
		end
	endtask

	// Sync pulse, only ever issued for quarter rate
	task automatic sync_pulse;
		@(posedge clk_sys_in);
		#1 sync_out = 1'b1;
		repeat (4) @(posedge clk_sys_in);
		#1 sync_out = 1'b0;
		repeat (4) @(posedge clk_sys_in);
		#1 qr = armed;
	endtask
endmodule // mrf_ctrl_model

`default_nettype wire

// *** tb/test_mrf_mode_register.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Mode register bench
// ----------------------------------------
module test_mrf_mode_register;
	logic              clk_sys_in;
	logic              resetn_in;
	logic              ck;
	logic [4:0]        cmd_n;
	logic [21:0]       word;
	logic              sync;
	logic              dq0;
	logic              pdown;
	logic              rwr;
	logic [3:0]        rbank;
	logic              ro_en;
	logic [1:0]        ro_page;
	logic [21:0]       mode;
	mrf_pkg::mrf_cfg_s cfg;
	logic              quart;
	logic              perdev;
	logic [7:0]        ro_data;
	logic [15:0]       perm;
	logic [15:0]       temp;
	int                fails = 0;
	int                checks_done = 0;
	int                cycles = 0;
	logic              seen;
	int                loads = 0;

	mrf_ctrl_model i_ctrl (.clk_sys_in(clk_sys_in), .ck_out(ck),
		.cmd_n_out(cmd_n), .word_out(word), .sync_out(sync));

	mrf_mode_register i_dut (
		.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .ck_in(ck),
		.cs_n_in(cmd_n[4]), .act_n_in(cmd_n[3]), .ras_n_in(cmd_n[2]),
		.cas_n_in(cmd_n[1]), .we_n_in(cmd_n[0]),
		.bank_group_in(word[21:20]), .bank_in(word[19:18]),
		.addr_in(word[17:0]), .dq0_select_in(dq0), .sync_pulse_in(sync),
		.power_down_in(pdown), .repair_write_in(rwr),
		.repair_bank_in(rbank), .readout_en_in(ro_en),
		.readout_page_in(ro_page), .mode_value_out(mode), .cfg_out(cfg),
		.quarter_rate_mode_out(quart), .per_device_mode_out(perdev),
		.readout_data_out(ro_data), .perm_repaired_out(perm),
		.temp_repaired_out(temp), .set_seen_out(seen));

	// System clock
	initial
	begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end

	// Hang guard, well above the 32 pin-clock periods used;
	// also counts load pulses so a repeated accept shows up
	always @(posedge clk_sys_in)
	begin
		cycles <= cycles + 1;
		if (seen === 1'b1)
			loads <= loads + 1;
		if (cycles == 4000)
		begin
			fails = fails + 1;
			report_and_stop;
		end
	end

	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Expected decode worked out from the field table
	function automatic mrf_pkg::mrf_cfg_s ecfg(input logic [21:0] w);
		logic [31:0] t;
		t = 32'h00865430 >> {w[8:6], 2'b00};
		return '{w[13], w[5], w[12], w[11], w[10], w[9], t[3:0],
			w[8:7] == 2'b11, w[4], w[3], w[2], w[1]};
	endfunction

	task automatic load(input logic [21:0] w);
		int n;
		n = loads;
		i_ctrl.send(w);
		cmp(32'(loads - n), 32'h1);
		cmp(32'(mode), 32'(w));
		cmp(32'(cfg), 32'(ecfg(w)));
	endtask

	task automatic t_fields;
		int n;
		for (int i = 1; i < 14; i++)
			load(22'h100000 | (22'h1 << i));
		for (int c = 0; c < 8; c++)
			load(22'h100000 | (22'(c) << 6));
		n = loads;
		i_ctrl.send(22'h142000);
		cmp(32'(mode), 32'h001001c0);
		cmp(32'(loads - n), 32'h0);
		$display("Field test done");
	endtask

	task automatic t_repair;
		load(22'h102020);
		@(posedge clk_sys_in);
		#1 rbank = 4'h3;
		rwr = 1'b1;
		repeat (6) @(posedge clk_sys_in);
		#1 rwr = 1'b0;
		repeat (6) @(posedge clk_sys_in);
		cmp(32'(perm), 32'h8);
		cmp(32'(temp), 32'h8);
		#1 pdown = 1'b1;
		repeat (6) @(posedge clk_sys_in);
		#1 pdown = 1'b0;
		cmp(32'(temp), 32'h0);
		cmp(32'(perm), 32'h8);
		ro_page = 2'h2;
		ro_en = 1'b1;
		@(posedge clk_sys_in);
		#1 ro_en = 1'b0;
		cmp(32'(ro_data), 32'hc0);
		$display("Repair test done");
	endtask

	task automatic t_gear;
		cmp(32'(quart), 32'h0);
		i_ctrl.send(22'h0c0008);
		cmp(32'(quart), 32'h0);
		i_ctrl.sync_pulse;
		cmp(32'(quart), 32'h1);
		load(22'h100080);
		i_ctrl.send(22'h0c0000);
		cmp(32'(quart), 32'h0);
		$display("Gear test done");
	endtask

	task automatic t_perdev;
		int n;
		i_ctrl.send(22'h0c0010);
		cmp(32'(perdev), 32'h1);
		dq0 = 1'b1;
		n = loads;
		i_ctrl.send(22'h100400);
		cmp(32'(mode), 32'h00100080);
		cmp(32'(loads - n), 32'h0);
		dq0 = 1'b0;
		load(22'h100400);
		i_ctrl.send(22'h0c0000);
		cmp(32'(perdev), 32'h0);
		$display("Per-device test done");
	endtask

	// Main sequence
	initial
	begin
		resetn_in = 1'b0;
		dq0 = 1'b0;
		pdown = 1'b0;
		rwr = 1'b0;
		rbank = 4'h0;
		ro_en = 1'b0;
		ro_page = 2'h0;
		repeat (10) @(posedge clk_sys_in);
		#1 resetn_in = 1'b1;
		repeat (4) @(posedge clk_sys_in);
		cmp(32'(mode), 32'h0);
		t_fields;
		t_repair;
		t_gear;
		t_perdev;
		report_and_stop;
	end
endmodule // test_mrf_mode_register

`default_nettype wire
